// ==== design/fdc_host_regs.sv ====
/*
 * Host register decode of the floppy controller with its drive
 * output register, configuration port, DMA gating, soft reset and
 * drive line outputs.
 * Assumes host strobes and pins synchronous to the 20 MHz clock;
 * the controller core and its registers sit outside this block.
 */
`timescale 1ns/1ps
`default_nettype none
module fdc_host_regs
    import fdc_regs_pkg::*;
#(
    parameter int         ADDR_W    = 10,
    parameter logic [9:0] BASE_ADDR = FDC_BASE_DEFAULT,
    parameter int         CFG_REGS  = 8
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    // Host I/O bus
    input  wire logic [ADDR_W-1:0] io_addr,
    input  wire logic              io_rd,
    input  wire logic              io_wr,
    input  wire logic        [7:0] io_wdata,
    output logic             [7:0] io_rdata,
    output logic             [7:0] io_rdata_oe,
    // Host DMA and interrupt pins
    input  wire logic              dack_n,
    input  wire logic              tc,
    output logic                   drq_o,
    output logic                   drq_oe,
    output logic                   irq_o,
    output logic                   irq_oe,
    // Controller core side
    input  wire logic        [7:0] status_a,
    input  wire logic        [7:0] status_b,
    input  wire logic        [7:0] core_rdata,
    input  wire logic              core_drq,
    input  wire logic              core_irq,
    output logic             [7:0] core_wdata,
    output logic             [7:0] core_rd_stb,
    output logic             [7:0] core_wr_stb,
    output logic                   core_rst_n,
    output logic                   core_dack_n,
    output logic                   core_tc,
    // Drive side, open drain
    output logic             [3:0] drive_select_lines,
    output logic             [3:0] drive_select_oe,
    output logic             [3:0] motor_lines,
    output logic             [3:0] motor_oe,
    // Block state
    output logic                   fdc_enabled,
    output logic                   cfg_mode
);

    ////////////////////////////////////////////////////////////////////
    // Address decode

    logic       base_hit;
    logic [2:0] ofs;
    logic       rd_q;
    logic       rd_start;
    logic       wr_hit;
    logic       rd_hit;

    assign base_hit = (io_addr[ADDR_W-1:3] == BASE_ADDR[ADDR_W-1:3]);
    assign ofs      = io_addr[2:0];
    assign rd_start = io_rd & ~rd_q;
    assign wr_hit   = io_wr & base_hit;
    assign rd_hit   = rd_start & base_hit;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_q <= 1'b0;
        end else begin
            rd_q <= io_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration port

    cfg_state_t cfg_state_q;
    logic [7:0] cfg_index_q;
    logic [7:0] cfg_q [CFG_REGS];
    logic       cfg_active;
    logic       cfg_idx_wr;
    logic       cfg_dat_wr;

    assign cfg_active = (cfg_state_q == CFG_ACTIVE);
    // Config ports share +0/+1 with the status reads, writes only
    assign cfg_idx_wr = wr_hit && (ofs == OFS_CFG_INDEX);
    assign cfg_dat_wr = wr_hit && (ofs == OFS_CFG_DATA);

    // Two enter keys in a row keep stray writes from unlocking it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_state_q <= CFG_IDLE;
        end else if (cfg_idx_wr) begin
            case (cfg_state_q)
                CFG_IDLE: begin
                    if (io_wdata == CFG_KEY_ENTER) begin
                        cfg_state_q <= CFG_KEY1;
                    end
                end
                CFG_KEY1: begin
                    if (io_wdata == CFG_KEY_ENTER) begin
                        cfg_state_q <= CFG_ACTIVE;
                    end else begin
                        cfg_state_q <= CFG_IDLE;
                    end
                end
                CFG_ACTIVE: begin
                    if (io_wdata == CFG_KEY_EXIT) begin
                        cfg_state_q <= CFG_IDLE;
                    end
                end
                default: begin
                    cfg_state_q <= CFG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_index_q <= CFG_INDEX_RESET;
        end else if (cfg_idx_wr && cfg_active
                     && io_wdata != CFG_KEY_EXIT) begin
            cfg_index_q <= io_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int i = 0; i < CFG_REGS; i++) begin
                cfg_q[i] <= CFG_RESET;
            end
        end else if (cfg_dat_wr && cfg_active
                     && cfg_index_q < 8'(CFG_REGS)) begin
            cfg_q[cfg_index_q[$clog2(CFG_REGS)-1:0]] <= io_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Floppy register strobes

    logic fdc_en;
    logic fl_wr;
    logic fl_rd;

    assign fdc_en = cfg_q[CFG_FDC_EN_IDX][CFG_FDC_EN_BIT];
    assign fl_wr  = wr_hit & fdc_en;
    assign fl_rd  = rd_hit & fdc_en;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            core_wr_stb <= 8'h00;
            core_rd_stb <= 8'h00;
            core_wdata  <= 8'h00;
        end else begin
            core_wr_stb <= 8'h00;
            core_rd_stb <= 8'h00;
            if (fl_wr && (ofs == OFS_DATA_RATE || ofs == OFS_FIFO
                          || ofs == OFS_RATE_CTRL)) begin
                core_wr_stb[ofs] <= 1'b1;
                core_wdata       <= io_wdata;
            end
            if (fl_rd && (ofs == OFS_MAIN_STATUS || ofs == OFS_FIFO
                          || ofs == OFS_DIGITAL_IN)) begin
                core_rd_stb[ofs] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Drive output and tape registers

    dor_if      dbus ();
    logic [7:0] dor_q;
    logic [1:0] tape_q;

    // Soft reset does not touch it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dor_q <= DOR_RESET;
        end else if (fl_wr && ofs == OFS_DRIVE_OUT) begin
            dor_q <= io_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tape_q <= TAPE_RESET;
        end else if (fl_wr && ofs == OFS_TAPE) begin
            tape_q <= io_wdata[1:0];
        end
    end

    assign dbus.dor  = dor_q;
    assign dbus.swap = cfg_q[CFG_FDC_EN_IDX][CFG_SWAP_BIT];

    ////////////////////////////////////////////////////////////////////
    // Host read data

    logic [7:0] rdata_q;
    logic [7:0] rd_oe_q;
    logic [7:0] rd_mux;
    logic [7:0] rd_mask;

    always_comb begin
        rd_mux  = 8'h00;
        rd_mask = 8'hFF;
        case (ofs)
            OFS_STATUS_A: begin
                rd_mux  = status_a;
                rd_mask = cfg_active ? 8'h00 : 8'hFF;
            end
            OFS_STATUS_B: begin
                rd_mux  = status_b;
                rd_mask = cfg_active ? 8'h00 : 8'hFF;
            end
            OFS_DRIVE_OUT: begin
                rd_mux = dor_q;
            end
            // Upper tape bits float on read
            OFS_TAPE: begin
                rd_mux  = {6'h00, tape_q};
                rd_mask = TAPE_RD_OE;
            end
            OFS_MAIN_STATUS, OFS_FIFO, OFS_DIGITAL_IN: begin
                rd_mux = core_rdata;
            end
            OFS_RESERVED: begin
                rd_mask = 8'h00;
            end
            default: begin
                rd_mask = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
            rd_oe_q <= 8'h00;
        end else if (fl_rd) begin
            rdata_q <= rd_mux;
            rd_oe_q <= rd_mask;
        end else if (!io_rd) begin
            rd_oe_q <= 8'h00;
        end
    end

    assign io_rdata    = rdata_q;
    assign io_rdata_oe = rd_oe_q;

    ////////////////////////////////////////////////////////////////////
    // DMA and interrupt gating

    logic dma_irq_enable;

    assign dma_irq_enable = dor_q[DOR_DMA_EN_BIT];

    assign drq_o       = core_drq;
    assign irq_o       = core_irq;
    assign drq_oe      = dma_irq_enable;
    assign irq_oe      = dma_irq_enable;
    assign core_dack_n = dma_irq_enable ? dack_n : 1'b1;
    assign core_tc     = dma_irq_enable & tc;

    ////////////////////////////////////////////////////////////////////
    // Soft reset and drive lines

    logic [3:0] sel_n;
    logic [3:0] mot_n;

    soft_reset_stretch #(
        .MIN_CYC (SOFT_RST_MIN_CYC)
    ) u_stretch (
        .clock (clock),
        .rst_n (rst_n),
        .dport (dbus.stretch)
    );

    drive_decode u_decode (
        .clock   (clock),
        .rst_n   (rst_n),
        .dport   (dbus.decode),
        .sel_n   (sel_n),
        .motor_n (mot_n)
    );

    assign core_rst_n = dbus.core_rst_n;

    // Open drain: value fixed low, enable pulls the line
    // Active low select
    assign drive_select_lines = 4'h0;
    assign drive_select_oe    = ~sel_n;
    assign motor_lines        = 4'h0;
    assign motor_oe           = ~mot_n;

    assign fdc_enabled = fdc_en;
    assign cfg_mode    = cfg_active;

endmodule : fdc_host_regs
`default_nettype wire

// ==== shared/fdc_regs_pkg.sv ====
/*
 * Constants for the floppy host register block: register offsets,
 * drive output field positions, reset values, configuration keys
 * and soft reset timing.
 * Assumes a single 20 MHz device clock and an 8-bit host I/O bus.
 */
package fdc_regs_pkg;

    // Offsets from the floppy base address
    localparam logic [2:0] OFS_CFG_INDEX   = 3'h0;
    localparam logic [2:0] OFS_CFG_DATA    = 3'h1;
    localparam logic [2:0] OFS_STATUS_A    = 3'h0;
    localparam logic [2:0] OFS_STATUS_B    = 3'h1;
    localparam logic [2:0] OFS_DRIVE_OUT   = 3'h2;
    localparam logic [2:0] OFS_TAPE        = 3'h3;
    localparam logic [2:0] OFS_MAIN_STATUS = 3'h4;
    localparam logic [2:0] OFS_DATA_RATE   = 3'h4;
    localparam logic [2:0] OFS_FIFO        = 3'h5;
    localparam logic [2:0] OFS_RESERVED    = 3'h6;
    localparam logic [2:0] OFS_DIGITAL_IN  = 3'h7;
    localparam logic [2:0] OFS_RATE_CTRL   = 3'h7;

    localparam logic [9:0] FDC_BASE_DEFAULT = 10'h3F0;

    // Drive output register fields, reset values and tape read enables
    localparam int DOR_SEL_LSB      = 0;
    localparam int DOR_SOFT_RST_BIT = 2;
    localparam int DOR_DMA_EN_BIT   = 3;
    localparam int DOR_MOTOR_LSB    = 4;
    localparam logic [7:0] DOR_RESET  = 8'h00;
    localparam logic [1:0] TAPE_RESET = 2'h0;
    localparam logic [7:0] TAPE_RD_OE = 8'h03;

    // Configuration port
    localparam logic [7:0] CFG_KEY_ENTER  = 8'h55;
    localparam logic [7:0] CFG_KEY_EXIT   = 8'hAA;
    localparam logic [7:0] CFG_RESET      = 8'h00;
    localparam logic [7:0] CFG_INDEX_RESET = 8'h00;
    localparam int         CFG_FDC_EN_IDX = 0;
    localparam int         CFG_FDC_EN_BIT = 0;
    localparam int         CFG_SWAP_BIT   = 1;

    // Soft reset minimum time
    localparam int SOFT_RST_MIN_NS  = 100;
    localparam int CLK_PERIOD_NS    = 50;
    localparam int SOFT_RST_MIN_CYC =
        (SOFT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        CFG_IDLE,
        CFG_KEY1,
        CFG_ACTIVE
    } cfg_state_t;

endpackage : fdc_regs_pkg

// ==== shared/dor_if.sv ====
/*
 * Carries the drive output register and the drive swap option from
 * the register block to its reset stretcher and drive decoder.
 * Assumes all parties run on the one device clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface dor_if;
    logic [7:0] dor;
    logic       swap;
    logic       core_rst_n;

    modport owner   (output dor, output swap, input core_rst_n);
    modport stretch (input dor, output core_rst_n);
    modport decode  (input dor, input swap);
endinterface : dor_if
`default_nettype wire

// ==== design/soft_reset_stretch.sv ====
/*
 * Turns the soft reset bit into a core reset held for a minimum
 * number of clocks, and holds it across power-up reset.
 * Assumes rst_n synchronous to clock.
 */
`timescale 1ns/1ps
`default_nettype none
module soft_reset_stretch
    import fdc_regs_pkg::*;
#(
    parameter int MIN_CYC = SOFT_RST_MIN_CYC
) (
    input  wire logic clock,
    input  wire logic rst_n,
    dor_if.stretch    dport
);
    localparam int CW = $clog2(MIN_CYC + 1);

    logic          active_q;
    logic [CW-1:0] cnt_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            active_q <= 1'b1;
            cnt_q    <= '0;
        end else if (!dport.dor[DOR_SOFT_RST_BIT]) begin
            active_q <= 1'b1;
            cnt_q    <= '0;
        end else if (active_q) begin
            if (cnt_q >= CW'(MIN_CYC - 1)) begin
                active_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    assign dport.core_rst_n = ~active_q;
endmodule : soft_reset_stretch
`default_nettype wire

// ==== design/drive_decode.sv ====
/*
 * Decodes the drive output register into active-low open-drain
 * drive select and motor lines, with optional swap of drives 0/1.
 * Assumes rst_n synchronous to clock.
 */
`timescale 1ns/1ps
`default_nettype none
module drive_decode
    import fdc_regs_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    dor_if.decode           dport,
    output logic      [3:0] sel_n,
    output logic      [3:0] motor_n
);
    logic [1:0] code;
    logic [3:0] mot;

    always_comb begin
        code = dport.dor[DOR_SEL_LSB +: 2];
        mot  = dport.dor[DOR_MOTOR_LSB +: 4];
        if (dport.swap && code[1] == 1'b0) begin
            code[0] = ~code[0];
        end
        if (dport.swap) begin
            mot = {mot[3:2], mot[0], mot[1]};
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sel_n   <= 4'hF;
            motor_n <= 4'hF;
        end else begin
            sel_n   <= ~(4'h1 << code);
            motor_n <= ~mot;
        end
    end
endmodule : drive_decode
`default_nettype wire

// ==== verif/fdc_host_regs_asserts.sv ====
/* Checker on the floppy register block top ports, bound below.
   Assumes one clock and the synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module fdc_host_regs_asserts
    import fdc_regs_pkg::*;
#(
    parameter int         ADDR_W    = 10,
    parameter logic [9:0] BASE_ADDR = FDC_BASE_DEFAULT
) (
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] io_addr,
    input wire logic              io_rd,
    input wire logic              io_wr,
    input wire logic        [7:0] io_wdata,
    input wire logic        [7:0] io_rdata_oe,
    input wire logic              dack_n,
    input wire logic              tc,
    input wire logic              drq_oe,
    input wire logic              irq_oe,
    input wire logic              core_rst_n,
    input wire logic              core_dack_n,
    input wire logic              core_tc,
    input wire logic        [3:0] drive_select_oe,
    input wire logic        [3:0] motor_oe,
    input wire logic              fdc_enabled,
    input wire logic              cfg_mode
);
    logic [2:0] ofs;
    logic       hit;
    logic       dor_wr;
    assign ofs    = io_addr[2:0];
    assign hit    = io_addr[ADDR_W-1:3] == BASE_ADDR[ADDR_W-1:3];
    assign dor_wr = io_wr && hit && ofs == OFS_DRIVE_OUT && fdc_enabled;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    property p_dma_off; !drq_oe |-> core_dack_n && !core_tc; endproperty
    a_dma_off: assert property (p_dma_off)
        else $error("dma inputs pass while disabled");
    property p_dma_on;
        drq_oe |-> irq_oe && core_dack_n == dack_n && core_tc == tc;
    endproperty
    a_dma_on: assert property (p_dma_on)
        else $error("dma inputs blocked while enabled");
    property p_dor;
        dor_wr |=> drq_oe == $past(io_wdata[3])
            ##1 motor_oe[3:2] == $past(io_wdata[7:6], 2);
    endproperty
    a_dor: assert property (p_dor)
        else $error("drive output fields not applied");
    property p_one_sel; $past(rst_n) |-> $onehot(drive_select_oe); endproperty
    a_one_sel: assert property (p_one_sel)
        else $error("drive select not one hot");
    property p_srst_hold; dor_wr && !io_wdata[2] |-> ##2 !core_rst_n; endproperty
    a_srst_hold: assert property (p_srst_hold)
        else $error("core reset not applied");
    sequence s_set;
        dor_wr && io_wdata[2] ##1 !dor_wr [*3];
    endsequence
    property p_srst_end; s_set |-> core_rst_n; endproperty
    a_srst_end: assert property (p_srst_end)
        else $error("core reset not released");
    property p_srst_min; $rose(core_rst_n) |-> !$past(core_rst_n, 2); endproperty
    a_srst_min: assert property (p_srst_min)
        else $error("core reset too short");
    property p_cfg_blk;
        $rose(io_rd) && cfg_mode && hit && ofs[2:1] == 2'h0 |=>
            io_rdata_oe == 8'h00;
    endproperty
    a_cfg_blk: assert property (p_cfg_blk)
        else $error("status read in config mode");
    property p_off; $rose(io_rd) && !fdc_enabled |=> io_rdata_oe == 8'h00;
    endproperty
    a_off: assert property (p_off)
        else $error("read answered while disabled");
    property p_tape;
        $rose(io_rd) && hit && ofs == OFS_TAPE && fdc_enabled |=>
            io_rdata_oe == TAPE_RD_OE;
    endproperty
    a_tape: assert property (p_tape)
        else $error("tape read enables wrong");
    property p_cfg_wr;
        !cfg_mode && io_wr && hit && ofs == OFS_CFG_DATA |=> $stable(fdc_enabled);
    endproperty
    a_cfg_wr: assert property (p_cfg_wr)
        else $error("config changed outside config mode");
    c_srst: cover property ($rose(core_rst_n));
    c_dma: cover property (drq_oe && !core_dack_n);
    c_cfg: cover property ($rose(fdc_enabled));
endmodule : fdc_host_regs_asserts
bind fdc_host_regs fdc_host_regs_asserts #(
    .ADDR_W(ADDR_W),
    .BASE_ADDR(BASE_ADDR)
) u_chk (
    .clock, .rst_n, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata_oe,
    .dack_n, .tc, .drq_oe, .irq_oe, .core_rst_n, .core_dack_n, .core_tc,
    .drive_select_oe, .motor_oe, .fdc_enabled, .cfg_mode
);
`default_nettype wire

// ==== verif/host_io_model.sv ====
/* Host processor model: programmed I/O cycles on the 8-bit bus.
   Assumes the block samples on rising clock edges. */
`timescale 1ns/1ps
`default_nettype none
module host_io_model
    import fdc_regs_pkg::*;
(
    input  wire logic       clock,
    output var  logic [9:0] io_addr,
    output var  logic       io_rd,
    output var  logic       io_wr,
    output var  logic [7:0] io_wdata,
    input  wire logic [7:0] io_rdata,
    input  wire logic [7:0] io_rdata_oe
);
    int slow = 0;
    initial begin
        io_addr  = 10'h000;
        io_rd    = 1'b0;
        io_wr    = 1'b0;
        io_wdata = 8'h00;
    end
    ////////////////////////////////////////
    // Programmed write, one or two
    task automatic wr(input logic [2:0] ofs, input logic [7:0] d0, d1,
                      input int n);
        @(negedge clock);
        io_addr  = FDC_BASE_DEFAULT + 10'(ofs);
        io_wdata = d0;
        io_wr    = 1'b1;
        if (n > 1) begin
            @(negedge clock);
            io_wdata = d1;
        end
        @(negedge clock);
        io_wr    = 1'b0;
        // Released lines never keep the old value
        io_addr  = ~io_addr;
        io_wdata = ~io_wdata;
    endtask : wr
    task automatic rd(input logic [2:0] ofs, output logic [7:0] d, oe);
        @(negedge clock);
        io_addr = FDC_BASE_DEFAULT + 10'(ofs);
        io_rd   = 1'b1;
        repeat (2 + slow) @(posedge clock);
        @(negedge clock);
        d       = io_rdata;
        oe      = io_rdata_oe;
        io_rd   = 1'b0;
        io_addr = ~io_addr;
    endtask : rd
endmodule : host_io_model
`default_nettype wire

// ==== verif/fdc_host_regs_tb.sv ====
/* Self-checking bench for the floppy register block.
   Assumes the host model owns the bus; core side pins come from here. */
`timescale 1ns/1ps
`default_nettype none
module fdc_host_regs_tb
    import fdc_regs_pkg::*;
();
    logic            clock, rst_n, dack_n, tc, core_drq, core_irq;
    logic      [7:0] core_rdata, v;
    wire logic [9:0] io_addr;
    wire logic       io_rd, io_wr, drq_o, drq_oe, irq_o, irq_oe;
    wire logic       core_rst_n, core_dack_n, core_tc, fdc_enabled, cfg_mode;
    wire logic [7:0] io_wdata, io_rdata, io_rdata_oe, core_wdata;
    wire logic [7:0] core_rd_stb, core_wr_stb;
    logic      [7:0] last_rd_stb = 8'h00;
    wire logic [3:0] drive_select_lines, drive_select_oe, motor_lines, motor_oe;
    int              num_errors = 0;
    int              total_checks = 0;
    int              cycles = 0;
    host_io_model host (.clock, .io_addr, .io_rd, .io_wr, .io_wdata,
        .io_rdata, .io_rdata_oe);
    fdc_host_regs dut (.clock, .rst_n, .io_addr, .io_rd, .io_wr, .io_wdata,
        .io_rdata, .io_rdata_oe, .dack_n, .tc, .drq_o, .drq_oe, .irq_o,
        .irq_oe, .status_a(8'hA5), .status_b(8'h5A), .core_rdata, .core_drq,
        .core_irq, .core_wdata, .core_rd_stb, .core_wr_stb, .core_rst_n,
        .core_dack_n, .core_tc, .drive_select_lines, .drive_select_oe,
        .motor_lines, .motor_oe, .fdc_enabled, .cfg_mode);
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic rdchk(input logic [2:0] ofs, input logic [7:0] ed, eo,
                         input string nm);
        logic [7:0] d;
        logic [7:0] o;
        host.rd(ofs, d, o);
        chk({nm, "_oe"}, eo, o);
        if (eo != 8'h00)
            chk(nm, ed, d);
    endtask : rdchk
    task automatic give_verdict();
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Read strobes last one cycle, so catch them mid-cycle
    always @(negedge clock) begin
        if (core_rd_stb != 8'h00)
            last_rd_stb <= core_rd_stb;
    end
    // Hang guard, run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        rst_n = 1'b0;
        dack_n = 1'b1;
        tc = 1'b0;
        core_drq = 1'b0;
        core_irq = 1'b0;
        core_rdata = 8'h3C;
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        repeat (2) @(negedge clock);
        chk("dma_oe", 8'h00, {6'h0, irq_oe, drq_oe});
        chk("select", 8'h01, {4'h0, drive_select_oe});
        chk("sel_line", 8'h00, {motor_lines, drive_select_lines});
        host.wr(OFS_DRIVE_OUT, 8'h1C, 8'h00, 1);
        rdchk(OFS_DRIVE_OUT, 8'h00, 8'h00, "dor_off");
        chk("motor", 8'h00, {4'h0, motor_oe});
        host.wr(OFS_CFG_DATA, 8'h01, 8'h00, 1);
        chk("enabled", 8'h00, {7'h0, fdc_enabled});
        host.wr(OFS_CFG_INDEX, CFG_KEY_ENTER, CFG_KEY_ENTER, 2);
        chk("cfg_mode", 8'h01, {7'h0, cfg_mode});
        host.wr(OFS_CFG_INDEX, 8'h00, 8'h00, 1);
        host.wr(OFS_CFG_DATA, 8'h01, 8'h00, 1);
        host.wr(OFS_CFG_INDEX, CFG_KEY_EXIT, 8'h00, 1);
        chk("enabled", 8'h01, {cfg_mode, 6'h0, fdc_enabled});
        rdchk(OFS_STATUS_A, 8'hA5, 8'hFF, "status_a");
        host.wr(OFS_CFG_INDEX, CFG_KEY_ENTER, CFG_KEY_ENTER, 2);
        rdchk(OFS_STATUS_B, 8'h00, 8'h00, "status_b");
        host.wr(OFS_CFG_INDEX, CFG_KEY_EXIT, 8'h00, 1);
        for (int i = 0; i < 4; i++) begin
            v = 8'h10 << i | 8'h0C | 8'(i);
            host.wr(OFS_DRIVE_OUT, v, 8'h00, 1);
            repeat (3) @(negedge clock);
            chk("select", 8'h01 << i, {4'h0, drive_select_oe});
            chk("motor", 8'h01 << i, {4'h0, motor_oe});
            chk("dma_oe", 8'h03, {6'h0, irq_oe, drq_oe});
            chk("core_rst", 8'h01, {7'h0, core_rst_n});
            rdchk(OFS_DRIVE_OUT, v, 8'hFF, "dor");
        end
        dack_n = 1'b0;
        tc = 1'b1;
        core_drq = 1'b1;
        core_irq = 1'b1;
        @(negedge clock);
        chk("dma_in", 8'h07,
            {4'h0, core_dack_n, core_tc, irq_o, drq_o});
        host.wr(OFS_DRIVE_OUT, 8'h87, 8'h00, 1);
        @(negedge clock);
        chk("dma_gate", 8'h01, {5'h0, drq_oe, core_tc, core_dack_n});
        dack_n = 1'b1;
        tc = 1'b0;
        // Soft reset holds, keeps the rest
        host.wr(OFS_DATA_RATE, 8'h96, 8'h00, 1);
        chk("wr_stb", 8'h10, core_wr_stb);
        host.wr(OFS_DRIVE_OUT, 8'h83, 8'h00, 1);
        repeat (4) @(negedge clock);
        chk("core_rst", 8'h00, {7'h0, core_rst_n});
        chk("sel_mtr", 8'h88, {motor_oe, drive_select_oe});
        chk("core_wdata", 8'h96, core_wdata);
        rdchk(OFS_DRIVE_OUT, 8'h83, 8'hFF, "dor");
        // Release, then back-to-back clear and set
        host.wr(OFS_DRIVE_OUT, 8'h87, 8'h00, 1);
        repeat (3) @(negedge clock);
        chk("core_rst", 8'h01, {7'h0, core_rst_n});
        host.wr(OFS_DRIVE_OUT, 8'h83, 8'h87, 2);
        chk("core_rst", 8'h00, {7'h0, core_rst_n});
        @(negedge clock);
        chk("core_rst", 8'h00, {7'h0, core_rst_n});
        repeat (2) @(negedge clock);
        chk("core_rst", 8'h01, {7'h0, core_rst_n});
        // Decode of remaining offsets, one slow read
        rdchk(OFS_RESERVED, 8'h00, 8'h00, "reserved");
        host.wr(OFS_TAPE, 8'hFF, 8'h00, 1);
        rdchk(OFS_TAPE, 8'h03, TAPE_RD_OE, "tape");
        host.wr(OFS_FIFO, 8'h5A, 8'h00, 1);
        chk("wr_stb", 8'h20, core_wr_stb);
        host.wr(OFS_RATE_CTRL, 8'h02, 8'h00, 1);
        chk("wr_stb", 8'h80, core_wr_stb);
        host.slow = 1;
        rdchk(OFS_FIFO, 8'h3C, 8'hFF, "fifo");
        chk("rd_stb", 8'h20, last_rd_stb);
        host.slow = 0;
        rdchk(OFS_DIGITAL_IN, 8'h3C, 8'hFF, "dig_in");
        chk("rd_stb", 8'h80, last_rd_stb);
        rdchk(OFS_MAIN_STATUS, 8'h3C, 8'hFF, "main_st");
        chk("rd_stb", 8'h10, last_rd_stb);
        // Swap option moves drive 0 onto line 1
        host.wr(OFS_CFG_INDEX, CFG_KEY_ENTER, CFG_KEY_ENTER, 2);
        host.wr(OFS_CFG_DATA, 8'h03, 8'h00, 1);
        host.wr(OFS_CFG_INDEX, CFG_KEY_EXIT, 8'h00, 1);
        host.wr(OFS_DRIVE_OUT, 8'h1C, 8'h00, 1);
        repeat (2) @(negedge clock);
        chk("swap", 8'h22, {motor_oe, drive_select_oe});
        give_verdict();
    end
endmodule : fdc_host_regs_tb
`default_nettype wire
